// >>> core/irs_pkg.sv
// package: constants and bus carriers for the integrator readout sequencer
package irs_pkg;
  localparam int          IRS_CHANNELS      = 64;
  localparam int          IRS_DATA_W        = 12;
  localparam int          IRS_DRIVERS       = 2;
  localparam int          IRS_STEP_DIV      = 4;
  localparam int          IRS_SEQ_SKEW      = 2;
  localparam int          IRS_RST_SW_SEQ    = 32;
  localparam int          IRS_RST_SW_SIM    = 8;
  localparam int          IRS_BYPASS_FALLS  = 64;
  localparam int          IRS_CASC_DEPTH    = 8;
  // register map, byte addresses
  localparam logic [31:0] IRS_CTRL_OFS      = 32'h0000_0000;
  localparam logic [31:0] IRS_STAT_OFS      = 32'h0000_0004;
  localparam logic [31:0] IRS_CTRL_RST      = 32'h0000_0003;
  localparam int          IRS_CTRL_TAP_LSB  = 0;
  localparam int          IRS_CTRL_TAP_W    = 3;
  localparam int          IRS_STAT_STEP_LSB = 0;
  localparam int          IRS_STAT_EOC_BIT  = 8;
  localparam int          IRS_STAT_HIZ_BIT  = 9;
  localparam int          IRS_STAT_RSW_BIT  = 10;
  localparam int          IRS_STAT_BYP_BIT  = 11;
  localparam int          IRS_STAT_RNG_LSB  = 12;
  localparam int          IRS_STAT_SIM_BIT  = 15;
  localparam int          IRS_STAT_DN_BIT   = 16;
  localparam int          IRS_STAT_PD_BIT   = 17;
  localparam int          IRS_STAT_NAP_BIT  = 18;
  localparam logic [1:0]  IRS_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  IRS_RESP_SLVERR   = 2'h2;
  // pin vector positions
  localparam int          IRS_P_RCLK  = 0;
  localparam int          IRS_P_START = 1;
  localparam int          IRS_P_ICLR  = 2;
  localparam int          IRS_P_SHS   = 3;
  localparam int          IRS_P_SHR   = 4;
  localparam int          IRS_P_FBW   = 5;
  localparam int          IRS_P_PDN   = 6;
  localparam int          IRS_P_NAPN  = 7;
  localparam int          IRS_P_HIZ   = 8;
  localparam int          IRS_P_RNG0  = 9;
  localparam int          IRS_P_POL   = 12;
  localparam int          IRS_P_MODE  = 13;
  localparam int          IRS_PINS    = 14;

  typedef enum logic [1:0] {
    IRS_IDLE  = 2'b00,
    IRS_ARMED = 2'b01,
    IRS_READ  = 2'b10,
    IRS_DONE  = 2'b11
  } irs_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } irs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } irs_axi_rsp_t;
endpackage : irs_pkg

// >>> core/irs_sequencer.sv
// integrator readout sequencer: pin sequencing, cds hold, output drivers, axi4-lite status
//
// What this block does
// R1: simultaneous mode advances channel every readout rising edge
// R2: sequential mode advances every fourth readout rising edge
// R3: start rising edge clears channel counter
// R4: start falling edge begins shifting data out
// R5: end-of-conversion low only during active read
// R6: cascade output is delayed copy of start
// R7: hiz enable floats drivers after 64 channels
// R8: clear rising edge starts integrator reset
// R9: signal strobe captures post-integration level, all channels
// R10: reset strobe captures reset level, all channels
// R11: filter bandwidth follows bandwidth control level
// R12: controller raises bandwidth early, drops late
// R13: power-down input low enters power-down
// R14: nap input low enters nap mode
// R15: three range inputs form binary range number
// R16: polarity high integrates downward from positive reference
// R17: polarity low integrates upward from negative reference
// R18: mode high drives both drivers together
// R19: mode low skews driver 0 two clocks
// R20: reset switch closed 32 or 8 clocks
// R21: filter bypass opens on 64th falling edge
// R22: counter stops after 64 channels until restart
`timescale 1ns/1ps
module irs_sequencer
  import irs_pkg::*;
#(
  parameter int CHANNELS = irs_pkg::IRS_CHANNELS,
  parameter int DATA_W   = irs_pkg::IRS_DATA_W
) (
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  input  wire logic                                 readout_clk,
  input  wire logic                                 readout_start_in,
  input  wire logic                                 integrator_clear,
  input  wire logic                                 signal_sample_strobe,
  input  wire logic                                 reset_sample_strobe,
  input  wire logic                                 filter_bw_ctrl,
  input  wire logic                                 power_down_n,
  input  wire logic                                 nap_n,
  input  wire logic                                 output_hiz_enable,
  input  wire logic                                 range_sel_msb,
  input  wire logic                                 range_sel_mid,
  input  wire logic                                 range_sel_lsb,
  input  wire logic                                 polarity_select,
  input  wire logic                                 output_mode_select,
  input  wire logic [CHANNELS-1:0][DATA_W-1:0]      integ_level,
  output logic      [irs_pkg::IRS_DRIVERS-1:0][DATA_W-1:0] diff_out_pos,
  output logic      [irs_pkg::IRS_DRIVERS-1:0][DATA_W-1:0] diff_out_neg,
  output logic      [irs_pkg::IRS_DRIVERS-1:0]      diff_out_oe,
  output logic                                      eoc,
  output logic                                      start_cascade_out,
  output logic                                      integ_reset_sw,
  output logic                                      filter_bypass_sw,
  output logic                                      filter_high_bw,
  output logic                                      power_down_active,
  output logic                                      nap_active,
  output logic      [2:0]                           range_num,
  output logic                                      integrate_down,
  input  wire irs_pkg::irs_axi_req_t                axi_req,
  output irs_pkg::irs_axi_rsp_t                     axi_rsp
);
  import irs_pkg::*;

  localparam int HALF   = CHANNELS / 2;
  localparam int STEP_W = $clog2(HALF + 1);

  // sync flops reset to idle pin levels: no false power-down or edge after reset
  localparam logic [IRS_PINS-1:0] PIN_IDLE = IRS_PINS'((1 << IRS_P_PDN) | (1 << IRS_P_NAPN));
  // pin synchronisers: s1 feeds only s2
  logic [IRS_PINS-1:0] pins_raw;
  logic [IRS_PINS-1:0] s1_q;
  logic [IRS_PINS-1:0] s2_q;
  logic [IRS_PINS-1:0] s3_q;
  assign pins_raw = {output_mode_select, polarity_select, range_sel_msb, range_sel_mid, range_sel_lsb,
                     output_hiz_enable, nap_n, power_down_n, filter_bw_ctrl, reset_sample_strobe,
                     signal_sample_strobe, integrator_clear, readout_start_in, readout_clk};
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire [IRS_PINS-1:0] rise = s2_q & ~s3_q;
  wire [IRS_PINS-1:0] fall = ~s2_q & s3_q;
  wire rclk_rise  = rise[IRS_P_RCLK];
  wire rclk_fall  = fall[IRS_P_RCLK];
  wire start_rise = rise[IRS_P_START];
  wire start_fall = fall[IRS_P_START];
  wire simult     = s2_q[IRS_P_MODE];
  wire pd_on      = ~s2_q[IRS_P_PDN];

  // static mode decodes
  assign filter_high_bw    = s2_q[IRS_P_FBW];               // R11
  assign power_down_active = pd_on;                         // R13
  assign nap_active        = ~s2_q[IRS_P_NAPN];             // R14
  assign range_num         = s2_q[IRS_P_RNG0 +: 3];         // R15
  assign integrate_down    = s2_q[IRS_P_POL];               // R16 R17

  // integrator reset and filter bypass, timed in readout falling edges
  logic [6:0] fall_cnt_q;
  logic       rst_window_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      fall_cnt_q   <= '0;
      rst_window_q <= 1'b0;
    end else if (rise[IRS_P_ICLR]) begin                    // R8
      fall_cnt_q   <= '0;
      rst_window_q <= 1'b1;
    end else if (rst_window_q && rclk_fall) begin
      fall_cnt_q   <= fall_cnt_q + 7'h01;
      rst_window_q <= (fall_cnt_q != 7'(IRS_BYPASS_FALLS - 1));
    end
  end
  wire [6:0] rsw_limit = simult ? 7'(IRS_RST_SW_SIM) : 7'(IRS_RST_SW_SEQ);
  assign integ_reset_sw   = rst_window_q && (fall_cnt_q < rsw_limit); // R20
  assign filter_bypass_sw = rst_window_q;                              // R21

  // cds hold: reset level and signal level per channel
  logic [CHANNELS-1:0][DATA_W-1:0] rst_lvl_q;
  logic [CHANNELS-1:0][DATA_W-1:0] sig_lvl_q;
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_cds
      always_ff @(posedge clk) begin
        if (reset) begin
          rst_lvl_q[gi] <= '0;
          sig_lvl_q[gi] <= '0;
        end else begin
          if (rise[IRS_P_SHR]) rst_lvl_q[gi] <= integ_level[gi]; // R10
          if (rise[IRS_P_SHS]) sig_lvl_q[gi] <= integ_level[gi]; // R9
        end
      end
    end
  endgenerate

  // held difference; sign follows the integration direction
  function automatic logic [DATA_W-1:0] cds_diff(input logic [DATA_W-1:0] r, input logic [DATA_W-1:0] s,
                                                 input logic down);
    cds_diff = down ? DATA_W'(r - s) : DATA_W'(s - r);     // R16 R17
  endfunction : cds_diff

  // readout sequencer
  irs_state_t        state_q;
  logic [STEP_W-1:0] step_q;
  logic [1:0]        div_q;
  logic [1:0]        tail_q;
  wire step_now = (state_q == IRS_READ) && rclk_rise && (simult || div_q == 2'(IRS_STEP_DIV - 1)); // R1 R2
  wire last_step = step_now && (step_q == STEP_W'(HALF - 1));
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= IRS_IDLE;
      step_q  <= '0;
      div_q   <= '0;
    end else if (start_rise) begin                          // R3
      state_q <= IRS_ARMED;
      step_q  <= '0;
      div_q   <= '0;
    end else begin
      case (state_q)
        IRS_ARMED: begin
          if (start_fall) state_q <= IRS_READ;              // R4
        end
        IRS_READ: begin
          if (rclk_rise) div_q <= div_q + 2'h1;
          if (step_now) step_q <= step_q + STEP_W'(1);
          if (last_step) state_q <= IRS_DONE;               // R22
        end
        default: state_q <= state_q;
      endcase
    end
  end
  assign eoc = (state_q != IRS_READ);                       // R5

  // driver data; driver 0 carries the low half, driver 1 the high half
  logic [DATA_W-1:0] d0_cur_q;
  logic [DATA_W-1:0] d1_cur_q;
  logic [IRS_SEQ_SKEW-1:0][DATA_W-1:0] skew_q;
  wire  [$clog2(CHANNELS)-1:0] ch_lo = ($clog2(CHANNELS))'(step_q);
  wire  [$clog2(CHANNELS)-1:0] ch_hi = ($clog2(CHANNELS))'(step_q + STEP_W'(HALF));
  always_ff @(posedge clk) begin
    if (reset) begin
      d0_cur_q <= '0;
      d1_cur_q <= '0;
      skew_q   <= '0;
      tail_q   <= '0;
    end else begin
      if (step_now) begin
        d0_cur_q <= cds_diff(rst_lvl_q[ch_lo], sig_lvl_q[ch_lo], integrate_down);
        d1_cur_q <= cds_diff(rst_lvl_q[ch_hi], sig_lvl_q[ch_hi], integrate_down);
      end
      // skew line moves on every readout rising edge so driver 0 lags by two clocks
      if (rclk_rise) begin
        skew_q[0] <= d0_cur_q;                              // R19
        skew_q[IRS_SEQ_SKEW-1] <= skew_q[0];
      end
      if (state_q != IRS_DONE) tail_q <= '0;
      else if (rclk_rise && tail_q != 2'(IRS_SEQ_SKEW)) tail_q <= tail_q + 2'h1;
    end
  end
  wire [DATA_W-1:0] d0_out = simult ? d0_cur_q : skew_q[IRS_SEQ_SKEW-1]; // R18 R19
  // in sequential mode driver 0 still owes its last word, so hold off the float
  wire drained = (state_q == IRS_DONE) && (simult || tail_q == 2'(IRS_SEQ_SKEW));
  wire hiz     = pd_on || (s2_q[IRS_P_HIZ] && drained);    // R7 R13
  assign diff_out_pos[0] = d0_out;
  assign diff_out_pos[1] = d1_cur_q;
  assign diff_out_neg[0] = ~d0_out;
  assign diff_out_neg[1] = ~d1_cur_q;
  assign diff_out_oe     = {IRS_DRIVERS{~hiz}};

  // cascade start delay: tap chosen by software
  logic [31:0]               ctrl_q;
  logic [IRS_CASC_DEPTH-1:0] casc_q;
  always_ff @(posedge clk) begin
    if (reset) casc_q <= '0;
    else       casc_q <= {casc_q[IRS_CASC_DEPTH-2:0], s2_q[IRS_P_START]};
  end
  assign start_cascade_out = casc_q[ctrl_q[IRS_CTRL_TAP_LSB +: IRS_CTRL_TAP_W]]; // R6

  // axi4-lite slave, one write and one read at a time
  logic        aw_q;
  logic        w_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  wire aw_take = axi_req.awvalid && !aw_q && !bvalid_q;
  wire w_take  = axi_req.wvalid && !w_q && !bvalid_q;
  wire wr_go   = aw_q && w_q && !bvalid_q;
  wire wr_ctrl = (awaddr_q[31:2] == IRS_CTRL_OFS[31:2]);
  wire wr_stat = (awaddr_q[31:2] == IRS_STAT_OFS[31:2]);
  wire ar_take = axi_req.arvalid && !rvalid_q;
  wire rd_ctrl = (axi_req.araddr[31:2] == IRS_CTRL_OFS[31:2]);
  wire rd_stat = (axi_req.araddr[31:2] == IRS_STAT_OFS[31:2]);

  logic [31:0] status;
  always_comb begin
    status = '0;
    status[IRS_STAT_STEP_LSB +: STEP_W] = step_q;
    status[IRS_STAT_EOC_BIT]            = eoc;
    status[IRS_STAT_HIZ_BIT]            = hiz;
    status[IRS_STAT_RSW_BIT]            = integ_reset_sw;
    status[IRS_STAT_BYP_BIT]            = filter_bypass_sw;
    status[IRS_STAT_RNG_LSB +: 3]       = range_num;
    status[IRS_STAT_SIM_BIT]            = simult;
    status[IRS_STAT_DN_BIT]             = integrate_down;
    status[IRS_STAT_PD_BIT]             = power_down_active;
    status[IRS_STAT_NAP_BIT]            = nap_active;
  end
  wire [31:0] rd_word = rd_ctrl ? ctrl_q : (rd_stat ? status : 32'h0000_0000);

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      bvalid_q <= 1'b0;
      bresp_q  <= IRS_RESP_OKAY;
      ctrl_q   <= IRS_CTRL_RST;
    end else begin
      if (aw_take) begin
        aw_q     <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end
      if (w_take) begin
        w_q     <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      if (wr_go) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_ctrl || wr_stat) ? IRS_RESP_OKAY : IRS_RESP_SLVERR;
        // only the tap field holds state; other bits read back as zero
        if (wr_ctrl && wstrb_q[0]) begin
          ctrl_q[IRS_CTRL_TAP_LSB +: IRS_CTRL_TAP_W] <= wdata_q[IRS_CTRL_TAP_LSB +: IRS_CTRL_TAP_W];
        end
      end else if (bvalid_q && axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= IRS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (rd_ctrl || rd_stat) ? IRS_RESP_OKAY : IRS_RESP_SLVERR;
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign axi_rsp.awready = !aw_q && !bvalid_q;
  assign axi_rsp.wready  = !w_q && !bvalid_q;
  assign axi_rsp.bvalid  = bvalid_q;
  assign axi_rsp.bresp   = bresp_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.rvalid  = rvalid_q;
  assign axi_rsp.rdata   = rdata_q;
  assign axi_rsp.rresp   = rresp_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_start_clears: assert property (start_rise |=> step_q == '0 && state_q == IRS_ARMED) // R3
    else $error("start rise did not clear counter");
  a_fall_reads: assert property (state_q == IRS_ARMED && start_fall && !start_rise |=> !eoc) // R4
    else $error("start fall did not begin read");
  a_eoc_read: assert property (!eoc && !start_rise |=> eoc == $past(last_step)) // R5
    else $error("eoc wrong during read");
  a_sim_step: assert property (state_q == IRS_READ && simult && rclk_rise && !start_rise && !last_step // R1
                               |=> step_q == $past(step_q) + STEP_W'(1))
    else $error("simultaneous step missed");
  a_seq_step: assert property (state_q == IRS_READ && !simult && rclk_rise && div_q != 2'h3 && !start_rise // R2
                               |=> step_q == $past(step_q))
    else $error("sequential stepped early");
  a_cascade_delay: assert property (ctrl_q[2:0] == 3'h0 && $stable(ctrl_q) // R6
                                    |-> start_cascade_out == $past(s2_q[IRS_P_START]))
    else $error("cascade delay wrong");
  a_hiz_done: assert property (state_q != IRS_DONE && !pd_on |-> diff_out_oe == '1) // R7
    else $error("drivers floated during read");
  a_rsw_sim: assert property (simult && rst_window_q && fall_cnt_q >= 7'h08 |-> !integ_reset_sw) // R20
    else $error("reset switch held too long");
  a_bypass_open: assert property (rst_window_q && rclk_fall && fall_cnt_q == 7'h3F && !rise[IRS_P_ICLR] // R21
                                  |=> !filter_bypass_sw)
    else $error("bypass did not open on 64th fall");
  a_stop_done: assert property (state_q == IRS_DONE && !start_rise |=> state_q == IRS_DONE && $stable(step_q)) // R22
    else $error("counter ran past last channel");
  a_clear_start: assert property (rise[IRS_P_ICLR] |=> integ_reset_sw && filter_bypass_sw) // R8
    else $error("integrator reset not started");
  a_range_map: assert property (range_num == {s2_q[IRS_P_RNG0+2], s2_q[IRS_P_RNG0+1], s2_q[IRS_P_RNG0]}) // R15
    else $error("range number misordered");

  // capture, skew and float checks
  a_sig_capture: assert property (rise[IRS_P_SHS] |=> sig_lvl_q == $past(integ_level)) // R9
    else $error("signal level not captured");
  a_rst_capture: assert property (rise[IRS_P_SHR] |=> rst_lvl_q == $past(integ_level)) // R10
    else $error("reset level not captured");
  a_skew_shift: assert property (rclk_rise |=> skew_q[IRS_SEQ_SKEW-1] == $past(skew_q[0])) // R19
    else $error("driver 0 skew line stalled");
  a_pd_float: assert property (pd_on |-> diff_out_oe == '0) // R13
    else $error("drivers active in power-down");
  a_drain_hold: assert property (state_q == IRS_DONE && !simult && tail_q != 2'(IRS_SEQ_SKEW) && !pd_on // R7
                                 |-> diff_out_oe == '1)
    else $error("drivers floated before last word");

  c_full_read: cover property (state_q == IRS_READ ##1 state_q == IRS_DONE);
  c_seq_read:  cover property (!simult && last_step);
  c_hiz:       cover property (state_q == IRS_DONE && diff_out_oe == '0);
  c_bus_rw:    cover property (bvalid_q && axi_req.bready ##[1:20] rvalid_q);
  c_seq_drain: cover property (!simult && state_q == IRS_DONE && tail_q == 2'(IRS_SEQ_SKEW) && diff_out_oe == '0);
endmodule : irs_sequencer

// >>> verif/integrator_readout_sequencer_tb.sv
// self-checking bench for the integrator readout sequencer
`timescale 1ns/1ps
module integrator_readout_sequencer_tb;
  import irs_pkg::*;
  logic                                   clk, reset, eoc, casc, rsw, byp, fhb, pda, napa, dn;
  logic [IRS_CHANNELS-1:0][IRS_DATA_W-1:0] lvl;
  logic [IRS_DRIVERS-1:0][IRS_DATA_W-1:0]  pos, neg;
  logic [IRS_DRIVERS-1:0]                  oe;
  logic [IRS_PINS-1:0]                     pins;
  logic [2:0]                              rng;
  logic [31:0]                             rd;
  logic [1:0]                              rr;
  irs_axi_req_t                            req;
  irs_axi_rsp_t                            rsp;
  int                                      mismatches, n_tests, i, k, m, d0, d7;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  irs_ctrl_model model_u (.clk(clk), .pins(pins));
  irs_sequencer dut_u (
    .clk(clk), .reset(reset), .readout_clk(pins[IRS_P_RCLK]), .readout_start_in(pins[IRS_P_START]),
    .integrator_clear(pins[IRS_P_ICLR]), .signal_sample_strobe(pins[IRS_P_SHS]),
    .reset_sample_strobe(pins[IRS_P_SHR]), .filter_bw_ctrl(pins[IRS_P_FBW]), .power_down_n(pins[IRS_P_PDN]),
    .nap_n(pins[IRS_P_NAPN]), .output_hiz_enable(pins[IRS_P_HIZ]), .range_sel_msb(pins[IRS_P_RNG0+2]),
    .range_sel_mid(pins[IRS_P_RNG0+1]), .range_sel_lsb(pins[IRS_P_RNG0]), .polarity_select(pins[IRS_P_POL]),
    .output_mode_select(pins[IRS_P_MODE]), .integ_level(lvl), .diff_out_pos(pos), .diff_out_neg(neg),
    .diff_out_oe(oe), .eoc(eoc), .start_cascade_out(casc), .integ_reset_sw(rsw), .filter_bypass_sw(byp),
    .filter_high_bw(fhb), .power_down_active(pda), .nap_active(napa), .range_num(rng),
    .integrate_down(dn), .axi_req(req), .axi_rsp(rsp));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic bound(input int j);
    if (j >= 50) begin
      mismatches++;
      test_done();
    end
  endtask : bound
  // pre-edge sampling: rsp read right after the edge is what that edge saw
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    int j;
    @(posedge clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1, default: '0};
    j = 0;
    do begin
      @(posedge clk);
      j++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && j < 50);
    req.bready <= 1'b0;
    bound(j);
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a);
    int j;
    @(posedge clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    j = 0;
    do begin
      @(posedge clk);
      j++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && j < 50);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    bound(j);
  endtask : axi_rd
  // held difference: reset level 0x900, signal level 5 per channel, 12-bit wrap
  function automatic logic [11:0] ex(input int c, input logic pol);
    ex = pol ? 12'h900 - 12'(c * 5) : 12'(c * 5) - 12'h900;
  endfunction : ex
  task automatic levels(input logic s);
    @(posedge clk);
    for (int c = 0; c < IRS_CHANNELS; c++) lvl[c] <= s ? 12'(c * 5) : 12'h900;
  endtask : levels
  task automatic start_read;
    model_u.set_pin(IRS_P_START, 1'b1);
    axi_rd(IRS_STAT_OFS);
    chk("step", 0, rd[5:0]);
    model_u.set_pin(IRS_P_START, 1'b0);
    repeat (2) @(posedge clk);
    chk("eoc", 0, eoc);
  endtask : start_read
  initial begin
    req = '0;
    lvl = '0;
    reset = 1'b1;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    chk("eoc", 1, eoc);
    axi_rd(IRS_CTRL_OFS);
    chk("ctrl", IRS_CTRL_RST, rd);
    axi_rd(32'h0000_0040);
    chk("resp", IRS_RESP_SLVERR, rr);
    chk("rdata", 0, rd);
    axi_wr(IRS_STAT_OFS, 32'hFFFF_FFFF);
    axi_rd(IRS_STAT_OFS);
    chk("stat_eoc", 1, rd[IRS_STAT_EOC_BIT]);
    // cascade delay measured at tap 0 and tap 7
    for (k = 0; k < 2; k++) begin
      axi_wr(IRS_CTRL_OFS, k ? 32'h0000_0007 : 32'h0000_0000);
      fork
        model_u.set_pin(IRS_P_START, 1'b1);
        for (i = 0; i < 30 && casc !== 1'b1; i++) @(posedge clk);
      join
      if (k) d7 = i;
      else d0 = i;
      model_u.set_pin(IRS_P_START, 1'b0);
      repeat (12) @(posedge clk);
    end
    chk("casc_delay", 7, d7 - d0);
    for (m = 0; m < 8; m++) begin
      model_u.set_range(3'(m));
      chk("range", m, rng);
    end
    for (m = 0; m < 2; m++) begin
      for (i = IRS_P_FBW; i <= IRS_P_NAPN; i++) model_u.set_pin(i, m[0]);
      model_u.set_modes(m[0], 1'b0, 1'b0);
      chk("high_bw", m, fhb);
      chk("pd", 32'(m == 0), pda);
      chk("nap", 32'(m == 0), napa);
      chk("down", m, dn);
      if (m == 0) chk("oe_pd", 0, oe);
    end
    model_u.bw_window(10);
    chk("high_bw", 0, fhb);
    // reset switch and bypass windows, sequential then simultaneous
    for (m = 0; m < 2; m++) begin
      k = m ? IRS_RST_SW_SIM : IRS_RST_SW_SEQ;
      model_u.set_modes(1'b1, m[0], 1'b0);
      model_u.pulse(IRS_P_ICLR);
      chk("rsw", 1, rsw);
      chk("byp", 1, byp);
      model_u.rclk(k - 1);
      chk("rsw", 1, rsw);
      model_u.rclk(1);
      chk("rsw", 0, rsw);
      model_u.rclk(IRS_BYPASS_FALLS - k - 1);
      chk("byp", 1, byp);
      model_u.rclk(1);
      chk("byp", 0, byp);
    end
    levels(1'b0);
    model_u.pulse(IRS_P_SHR);
    levels(1'b1);
    model_u.pulse(IRS_P_SHS);
    model_u.set_modes(1'b1, 1'b1, 1'b1);
    start_read();
    for (k = 0; k < 32; k++) begin
      model_u.rclk(1);
      chk("drv0", ex(k, 1'b1), pos[0]);
      chk("drv1", ex(k + 32, 1'b1), pos[1]);
      chk("neg0", 12'(~ex(k, 1'b1)), neg[0]);
      chk("neg1", 12'(~ex(k + 32, 1'b1)), neg[1]);
    end
    repeat (2) @(posedge clk);
    chk("eoc", 1, eoc);
    chk("oe", 0, oe);
    model_u.rclk(2);
    chk("hold", ex(31, 1'b1), pos[0]);
    // sequential: driver 1 every 4th rise, driver 0 two rises behind
    model_u.set_modes(1'b0, 1'b0, 1'b0);
    start_read();
    model_u.rclk(4);
    chk("drv1", ex(32, 1'b0), pos[1]);
    model_u.rclk(3);
    chk("drv1", ex(32, 1'b0), pos[1]);
    model_u.rclk(1);
    chk("drv1", ex(33, 1'b0), pos[1]);
    chk("drv0", ex(0, 1'b0), pos[0]);
    model_u.rclk(2);
    chk("drv0", ex(1, 1'b0), pos[0]);
    model_u.rclk(118);
    repeat (2) @(posedge clk);
    chk("eoc", 1, eoc);
    chk("oe", 3, oe);
    // driver 0 still owes its last word: float waits two readout rises
    model_u.set_modes(1'b0, 1'b0, 1'b1);
    chk("oe", 3, oe);
    model_u.rclk(2);
    chk("drv0", ex(31, 1'b0), pos[0]);
    chk("oe", 0, oe);
    test_done();
  end
endmodule : integrator_readout_sequencer_tb

// >>> verif/irs_ctrl_model.sv
// controller model: drives the sequencer's control pins
`timescale 1ns/1ps
module irs_ctrl_model
  import irs_pkg::*;
(
  input  wire logic                clk,
  output logic      [IRS_PINS-1:0] pins
);
  initial begin
    pins = '0;
    pins[IRS_P_PDN] = 1'b1;
    pins[IRS_P_NAPN] = 1'b1;
  end
  // each level stands 4 clk: syncs and edge logic have settled on return
  task automatic set_pin(input int p, input logic v);
    @(posedge clk);
    pins[p] <= v;
    repeat (4) @(posedge clk);
  endtask : set_pin
  // mode pins move together, never during a read
  task automatic set_modes(input logic pol, input logic mode, input logic hiz);
    @(posedge clk);
    pins[IRS_P_POL]  <= pol;
    pins[IRS_P_MODE] <= mode;
    pins[IRS_P_HIZ]  <= hiz;
    repeat (4) @(posedge clk);
  endtask : set_modes
  task automatic set_range(input logic [2:0] r);
    @(posedge clk);
    pins[IRS_P_RNG0 +: 3] <= r;
    repeat (4) @(posedge clk);
  endtask : set_range
  task automatic pulse(input int p);
    set_pin(p, 1'b1);
    set_pin(p, 1'b0);
  endtask : pulse
  // readout clock stands still between calls
  task automatic rclk(input int n);
    repeat (n) pulse(IRS_P_RCLK);
  endtask : rclk
  // bandwidth up with panel switch on, down 5 clk (0.5 us) after it goes off
  task automatic bw_window(input int on_clk);
    set_pin(IRS_P_FBW, 1'b1);
    repeat (on_clk + 5) @(posedge clk);
    set_pin(IRS_P_FBW, 1'b0);
  endtask : bw_window
endmodule : irs_ctrl_model
